/* core/brc_regs.svh */
// Purpose: Offsets, field positions, reset values and timing counts of the readback checker.
// Assumes: APB with 32-bit data, one aligned word per register.
// Notes: Summary of operation list follows.
//
// Summary of operation
// - When enabled, repeatedly read back configuration memory and compute a CRC.
// - The CRC of the first complete pass is held as the golden signature.
// - Each later pass is compared with the golden signature; a difference is an upset.
// - A mismatch raises the mismatch flag and pulls init low; done stays high.
// - An option keeps the init pin out of error signalling.
// - The error flag stays up until the next comparison and stays if still wrong.
// - Without a new golden signature the error flag stays asserted until a pass matches again, the checker stops, or a release-interface command clears it.
// - Port, JTAG or parallel access stops the checker unharmed and clears its flag.
// - When that access ends, checking resumes only after the next release-interface command.
// - Until the release-interface command arrives the checker does not run.
// - The release-interface command resets the checker and clears all errors.
// - JTAG configuration instructions in the instruction register block the checker.
// - Dynamic memory words are masked and block RAM is skipped during readback.
// - Checking starts only after done is high and the interface is released.
// - Clock source is chosen by priority among port, user, master and pin clocks.
// - JTAG has top priority and takes the configuration bus whenever needed.
// - Shutdown-style partial reconfiguration recomputes the golden signature.
// - The golden-recompute command recomputes the golden signature.
// - Init behaves normally during configuration, then acts as upset status.
// - The init signalling choice is one bit in option register one.
`ifndef BRC_REGS_SVH
`define BRC_REGS_SVH

// ****************************************
// Register offsets
// ****************************************
`define BRC_OFS_CTRL 12'h000
`define BRC_OFS_OPT1 12'h004
`define BRC_OFS_CMD 12'h008
`define BRC_OFS_STAT 12'h00C
`define BRC_OFS_GOLD 12'h010
`define BRC_OFS_LAST 12'h014

// ****************************************
// Field positions
// ****************************************
`define BRC_CTRL_EN 0
`define BRC_OPT1_FRAME_ONLY 0
`define BRC_CMD_RELEASE 0
`define BRC_CMD_RECOMPUTE 1
`define BRC_CMD_HOLD_ASSERT 2
`define BRC_CMD_HOLD_RELEASE 3
`define BRC_STAT_MISMATCH 0
`define BRC_STAT_GOLDEN_OK 1
`define BRC_STAT_RUNNING 2
`define BRC_STAT_RELEASED 3
`define BRC_STAT_INIT_N 4

// ****************************************
// Reset values and timing
// ****************************************
`define BRC_CTRL_RST 32'h0000_0000
`define BRC_OPT1_RST 32'h0000_0000
`define BRC_CRC_INIT 32'hFFFF_FFFF
`define BRC_CRC_POLY 32'h04C1_1DB7
`define BRC_READ_LAT 2

`endif

/* core/brc_pkg.sv */
// Purpose: Types shared by the readback checker.
// Assumes: Constants live in brc_regs.svh.
// Notes: None.
package brc_pkg;

    typedef enum logic [1:0] {
        BRC_IDLE,
        BRC_READ,
        BRC_COMPARE
    } brc_state_e;

    // Configuration access ports that can take the bus
    typedef struct packed {
        logic jtag_active;
        logic port_active;
        logic parallel_active;
    } brc_access_s;

    // Clock source request lines, highest priority first
    typedef struct packed {
        logic port_present;
        logic user_clock_present;
        logic master_mode;
        logic slave_mode;
    } brc_clk_sel_s;

    typedef enum logic [2:0] {
        BRC_CLK_NONE,
        BRC_CLK_PORT,
        BRC_CLK_USER,
        BRC_CLK_MASTER,
        BRC_CLK_PIN
    } brc_clk_src_e;

endpackage : brc_pkg

/* core/brc_checker.sv */
// Purpose: Background readback CRC checker of configuration memory.
// Assumes: Memory read port answers a fixed latency after the request.
// Notes: Clock sources are gated into one pclk-based enable.
//
// The register offsets and the APB register port are this design's own decisions.
`timescale 1ns/1ps
`include "brc_regs.svh"

module brc_checker #(
    parameter int ADDR_W = 16,
    parameter int FRAME_WORDS = 1024
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Device status and access ports (asynchronous pins)
    input wire logic done_in,
    input wire brc_pkg::brc_access_s access_in,
    input wire logic [2:0] jtag_ir_cfg_in,
    input wire brc_pkg::brc_clk_sel_s clk_sel_in,
    input wire logic [3:0] clk_tick_in,
    // Configuration memory read port
    output logic [ADDR_W-1:0] mem_addr,
    output logic mem_rd,
    input wire logic [31:0] mem_data,
    input wire logic [31:0] mem_mask,
    input wire logic mem_skip,
    // Status
    output logic mismatch_flag,
    output logic init_n_out,
    output logic init_n_oe,
    output logic done_out,
    output logic running
);

    // ****************************************
    // Input synchronisers
    // ****************************************
    localparam int NSYNC = 12;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] s1;
    logic [NSYNC-1:0] s2;
    logic [NSYNC-1:0] s3;
    logic [NSYNC-1:0] sync_in;
    assign raw_in = {done_in, access_in, jtag_ir_cfg_in, clk_sel_in, clk_tick_in[0]};

    // Change is accepted only when second and third stage agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= '0;
            s2 <= '0;
            s3 <= '0;
            sync_in <= '0;
        end else begin
            s1 <= raw_in;
            s2 <= s1;
            s3 <= s2;
            for (int i = 0; i < NSYNC; i++) begin
                if (s2[i] == s3[i]) begin
                    sync_in[i] <= s3[i];
                end
            end
        end
    end

    logic done_s;
    brc_pkg::brc_access_s access_s;
    logic [2:0] jtag_cfg_s;
    brc_pkg::brc_clk_sel_s clk_sel_s;
    assign done_s = sync_in[11];
    assign access_s = sync_in[10:8];
    assign jtag_cfg_s = sync_in[7:5];
    assign clk_sel_s = sync_in[4:1];

    // Tick lines for all four sources; index 0 also enters the vector above but is unused there
    logic [3:0] t1;
    logic [3:0] t2;
    logic [3:0] t3;
    logic [3:0] tick_s;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t1 <= '0;
            t2 <= '0;
            t3 <= '0;
            tick_s <= '0;
        end else begin
            t1 <= clk_tick_in;
            t2 <= t1;
            t3 <= t2;
            for (int i = 0; i < 4; i++) begin
                if (t2[i] == t3[i]) begin
                    tick_s[i] <= t3[i];
                end
            end
        end
    end

    // ****************************************
    // Clock source choice
    // ****************************************
    function automatic brc_pkg::brc_clk_src_e pick_src(input brc_pkg::brc_clk_sel_s sel);
        if (sel.port_present) begin
            pick_src = brc_pkg::BRC_CLK_PORT;
        end else if (sel.user_clock_present) begin
            pick_src = brc_pkg::BRC_CLK_USER;
        end else if (sel.master_mode) begin
            pick_src = brc_pkg::BRC_CLK_MASTER;
        end else if (sel.slave_mode) begin
            pick_src = brc_pkg::BRC_CLK_PIN;
        end else begin
            pick_src = brc_pkg::BRC_CLK_NONE;
        end
    endfunction : pick_src

    brc_pkg::brc_clk_src_e src;
    logic tick_lvl;
    logic tick_prev;
    logic step;
    assign src = pick_src(clk_sel_s);

    // JTAG-only mode has no clock, so the checker never steps there
    always_comb begin
        unique case (src)
            brc_pkg::BRC_CLK_PORT: tick_lvl = tick_s[3];
            brc_pkg::BRC_CLK_USER: tick_lvl = tick_s[2];
            brc_pkg::BRC_CLK_MASTER: tick_lvl = tick_s[1];
            brc_pkg::BRC_CLK_PIN: tick_lvl = tick_s[0];
            default: tick_lvl = 1'b0;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tick_prev <= 1'b0;
        end else begin
            tick_prev <= tick_lvl;
        end
    end
    assign step = tick_lvl & ~tick_prev;

    // ****************************************
    // Registers
    // ****************************************
    logic enable;
    logic frame_only;
    logic released;
    logic recompute_req;
    logic golden_ok;
    logic [31:0] golden;
    logic [31:0] last_crc;
    logic wr_en;
    logic rd_en;
    logic cmd_wr;
    assign wr_en = psel & penable & pwrite;
    assign rd_en = psel & penable & ~pwrite;
    assign cmd_wr = wr_en && paddr == `BRC_OFS_CMD;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            enable <= 1'b0;
            frame_only <= 1'b0;
        end else if (wr_en) begin
            if (paddr == `BRC_OFS_CTRL) begin
                enable <= pwdata[`BRC_CTRL_EN];
            end
            if (paddr == `BRC_OFS_OPT1) begin
                frame_only <= pwdata[`BRC_OPT1_FRAME_ONLY];
            end
        end
    end

    // Any port access parks the interface until the next release command
    logic access_any;
    logic blocked;
    logic go;
    assign access_any = access_s.jtag_active | access_s.port_active | access_s.parallel_active;
    assign blocked = access_any | (|jtag_cfg_s);
    assign go = enable & released & done_s & ~blocked;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            released <= 1'b0;
        end else if (cmd_wr && pwdata[`BRC_CMD_RELEASE]) begin
            released <= 1'b1;
        end else if (access_any) begin
            released <= 1'b0;
        end
    end

    // Recompute request: set wins, consumed when a pass starts
    logic pass_start;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            recompute_req <= 1'b0;
        end else if (cmd_wr && (pwdata[`BRC_CMD_RECOMPUTE] || pwdata[`BRC_CMD_HOLD_RELEASE])) begin
            recompute_req <= 1'b1;
        end else if (pass_start) begin
            recompute_req <= 1'b0;
        end
    end

    // ****************************************
    // Readback engine
    // ****************************************
    brc_pkg::brc_state_e state;
    logic [ADDR_W-1:0] addr;
    logic [1:0] lat;
    logic [31:0] crc;
    logic take_golden;
    logic reset_run;
    assign reset_run = !go || (cmd_wr && pwdata[`BRC_CMD_RELEASE]);
    assign pass_start = (state == brc_pkg::BRC_IDLE) && go && step;

    function automatic logic [31:0] crc_word(input logic [31:0] c, input logic [31:0] d);
        logic [31:0] r;
        r = c;
        for (int i = 31; i >= 0; i--) begin
            r = (r[31] ^ d[i]) ? ((r << 1) ^ `BRC_CRC_POLY) : (r << 1);
        end
        crc_word = r;
    endfunction : crc_word

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= brc_pkg::BRC_IDLE;
            addr <= '0;
            lat <= '0;
            crc <= `BRC_CRC_INIT;
            mem_rd <= 1'b0;
            mem_addr <= '0;
            take_golden <= 1'b0;
        end else if (reset_run) begin
            state <= brc_pkg::BRC_IDLE;
            mem_rd <= 1'b0;
            lat <= '0;
        end else begin
            mem_rd <= 1'b0;
            unique case (state)
                brc_pkg::BRC_IDLE: begin
                    if (step) begin
                        state <= brc_pkg::BRC_READ;
                        addr <= '0;
                        crc <= `BRC_CRC_INIT;
                        take_golden <= !golden_ok || recompute_req;
                    end
                end
                brc_pkg::BRC_READ: begin
                    if (lat == 2'd0 && step) begin
                        mem_addr <= addr;
                        mem_rd <= 1'b1;
                        lat <= 2'(`BRC_READ_LAT);
                    end else if (lat == 2'd1) begin
                        lat <= 2'd0;
                        if (!mem_skip) begin
                            crc <= crc_word(crc, mem_data & ~mem_mask);
                        end
                        if (addr == ADDR_W'(FRAME_WORDS - 1)) begin
                            state <= brc_pkg::BRC_COMPARE;
                        end else begin
                            addr <= addr + 1'b1;
                        end
                    end else if (lat != 2'd0) begin
                        lat <= lat - 2'd1;
                    end
                end
                brc_pkg::BRC_COMPARE: begin
                    state <= brc_pkg::BRC_IDLE;
                end
                default: state <= brc_pkg::BRC_IDLE;
            endcase
        end
    end

    // ****************************************
    // Golden signature and error flags
    // ****************************************
    logic compare_now;
    assign compare_now = !reset_run && state == brc_pkg::BRC_COMPARE;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            golden <= '0;
            golden_ok <= 1'b0;
            last_crc <= '0;
        end else if (cmd_wr && pwdata[`BRC_CMD_RELEASE]) begin
            golden_ok <= 1'b0;
        end else if (compare_now) begin
            last_crc <= crc;
            if (take_golden) begin
                golden <= crc;
                golden_ok <= 1'b1;
            end
        end
    end

    // Flag is rewritten only by a comparison or cleared by reset_run, so it holds in between
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mismatch_flag <= 1'b0;
        end else if (reset_run) begin
            mismatch_flag <= 1'b0;
        end else if (compare_now && !take_golden) begin
            mismatch_flag <= (crc != golden);
        end
    end

    // Init drives low only after startup and only when signalling is allowed
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            init_n_out <= 1'b1;
            init_n_oe <= 1'b0;
            done_out <= 1'b0;
            running <= 1'b0;
        end else begin
            done_out <= done_s;
            running <= go && state != brc_pkg::BRC_IDLE;
            init_n_oe <= done_s && enable && !frame_only;
            if (reset_run) begin
                init_n_out <= 1'b1;
            end else if (compare_now && !take_golden) begin
                init_n_out <= !(crc != golden);
            end
        end
    end

    // ****************************************
    // APB read side
    // ****************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= 1'b0;
            prdata <= '0;
            if (psel && !penable) begin
                unique case (paddr)
                    `BRC_OFS_CTRL: prdata <= {31'h0000_0000, enable};
                    `BRC_OFS_OPT1: prdata <= {31'h0000_0000, frame_only};
                    `BRC_OFS_CMD: prdata <= '0;
                    `BRC_OFS_STAT: prdata <= {27'h000_0000, init_n_out, released,
                                              running, golden_ok, mismatch_flag};
                    `BRC_OFS_GOLD: prdata <= golden;
                    `BRC_OFS_LAST: prdata <= last_crc;
                    default: pslverr <= 1'b1;
                endcase
            end
        end
    end

    logic unused;
    assign unused = rd_en;

endmodule : brc_checker

/* dv/brc_checker_props.sv */
// Purpose: Concurrent checks on the readback checker ports.
// Assumes: Zero-wait APB; access pins held for many cycles.
// Notes: Bound from the testbench top file.
`timescale 1ns/1ps
module brc_checker_props #(
    parameter int ADDR_W = 16,
    parameter int FRAME_WORDS = 1024
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    // Device pins
    input wire logic done_in,
    input wire brc_pkg::brc_access_s access_in,
    input wire logic [2:0] jtag_ir_cfg_in,
    // Memory port and status
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mismatch_flag,
    input wire logic init_n_out,
    input wire logic done_out,
    input wire logic running
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Flag may only fall after a comparison or a clearing event
    logic last_rd;
    logic wr_acc;
    logic blk_in;
    assign last_rd = mem_rd && mem_addr == ADDR_W'(FRAME_WORDS - 1);
    assign wr_acc = psel && penable && pwrite;
    assign blk_in = |access_in || |jtag_ir_cfg_in || !done_in;

    // ****************************************
    // Sequences
    // ****************************************
    sequence apb_xfer_s;
        psel && !penable ##1 psel && penable;
    endsequence
    // Seven cycles cover the three-stage synchronisers and the output register
    sequence blocked_s;
        (|access_in || |jtag_ir_cfg_in) [*7];
    endsequence

    // ****************************************
    // Assertions
    // ****************************************
    apb_ready_a: assert property (apb_xfer_s |-> pready)
        else $error("pready missing in access phase");
    slverr_qual_a: assert property (pslverr |-> pready)
        else $error("pslverr without pready");
    flag_done_a: assert property (mismatch_flag |-> done_out)
        else $error("done dropped on mismatch");
    init_cause_a: assert property (!init_n_out |-> mismatch_flag)
        else $error("init low without mismatch");
    block_stop_a: assert property (blocked_s |-> !running && !mismatch_flag)
        else $error("checker runs while blocked");
    no_done_a: assert property ((!done_in) [*7] |-> !running)
        else $error("checker runs before done");
    flag_hold_a: assert property ($fell(mismatch_flag) |-> $past(last_rd, 3)
        || $past(wr_acc) || $past(wr_acc, 2) || $past(blk_in, 5))
        else $error("mismatch flag dropped early");
    rd_pulse_a: assert property (mem_rd |=> !mem_rd)
        else $error("read pulse too long");
    addr_range_a: assert property (mem_rd |-> mem_addr < FRAME_WORDS)
        else $error("read beyond frame");
    flag_sync_a: assert property ($rose(mismatch_flag) |-> $past(running))
        else $error("flag raised outside compare");
endmodule : brc_checker_props

/* dv/brc_mem_model.sv */
// Purpose: Configuration memory behind the readback checker.
// Assumes: Answer stands in the cycle after the read pulse is seen at an edge.
// Notes: Word 3 is dynamic and masked, word 5 is skipped block RAM.
`timescale 1ns/1ps
module brc_mem_model #(
    parameter int ADDR_W = 16
) (
    // Clock
    input wire logic pclk,
    // Read port
    input wire logic [ADDR_W-1:0] mem_addr,
    input wire logic mem_rd,
    output logic [31:0] mem_data,
    output logic [31:0] mem_mask,
    output logic mem_skip,
    // Flips bit 0 of word 2
    input wire logic upset
);
    logic rd_q = 1'b0;
    logic [ADDR_W-1:0] a_q = '0;
    logic [31:0] spin = 32'h0000_0000;
    always @(posedge pclk) begin
        rd_q <= mem_rd;
        spin <= spin + 32'h0000_0001;
        if (mem_rd) begin
            a_q <= mem_addr;
        end
    end
    always_comb begin
        // Never leave a stale value outside the answer slot
        mem_data = ~spin;
        mem_mask = 32'h0000_0000;
        mem_skip = 1'b0;
        if (rd_q) begin
            mem_data = 32'(a_q) * 32'h0101_0101 ^ {31'h0, upset && a_q == 2};
            if (a_q == 3) begin
                mem_data = spin;
                mem_mask = 32'hFFFF_FFFF;
            end
            mem_skip = a_q == 5;
        end
    end
endmodule : brc_mem_model

/* dv/brc_checker_tb.sv */
// Purpose: Self-checking bench of the readback checker.
// Assumes: FRAME_WORDS cut to 8, one step every eight clocks.
// Notes: Registers reached over APB only.
`timescale 1ns/1ps
`include "brc_regs.svh"
module brc_checker_tb;
    localparam int FW = 8;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, er;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, g0, mem_data, mem_mask;
    logic done_in, mem_rd, mem_skip, upset, mismatch_flag;
    logic init_n_out, init_n_oe, done_out, running;
    logic [2:0] jtag_ir_cfg_in, tk;
    logic [3:0] clk_tick_in, tick_en;
    logic [15:0] mem_addr;
    brc_pkg::brc_access_s access_in;
    brc_pkg::brc_clk_sel_s clk_sel_in;
    int failures, total_checks;

    brc_checker #(.FRAME_WORDS(FW)) i_brc_checker (.pclk, .presetn, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .done_in, .access_in,
        .jtag_ir_cfg_in, .clk_sel_in, .clk_tick_in, .mem_addr, .mem_rd, .mem_data,
        .mem_mask, .mem_skip, .mismatch_flag, .init_n_out, .init_n_oe, .done_out, .running);
    brc_mem_model i_brc_mem_model (.pclk, .mem_addr, .mem_rd, .mem_data, .mem_mask,
        .mem_skip, .upset);

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        tk <= tk + 3'h1;
        clk_tick_in <= {4{tk[2]}} & tick_en;
    end

    // ****************************************
    // Tasks
    // ****************************************
    task automatic summarize();
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : summarize

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask : chk

    // Idle cycle after each transfer keeps psel single-driven per step
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] q, output logic e);
        int n;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        q = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
        if (n == 20) begin
            failures++;
            summarize();
        end
    endtask : apb

    task automatic wait_stat(input int b, input logic v);
        int n;
        n = 0;
        do begin
            apb(1'b0, `BRC_OFS_STAT, 32'h0000_0000, rd, er);
            n++;
        end while (rd[b] !== v && n < 300);
        chk("stat bit", 32'(v), 32'(rd[b]));
        if (rd[b] !== v) begin
            summarize();
        end
    endtask : wait_stat

    // ****************************************
    // Sequence
    // ****************************************
    initial begin
        {psel, penable, pwrite, paddr, pwdata, tk, clk_tick_in} = '0;
        {presetn, done_in, upset, jtag_ir_cfg_in, access_in, clk_sel_in} = '0;
        failures = 0;
        total_checks = 0;
        tick_en = 4'hF;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, `BRC_OFS_CTRL, 32'h0000_0000, rd, er);
        chk("ctrl", `BRC_CTRL_RST, rd);
        apb(1'b0, `BRC_OFS_OPT1, 32'h0000_0000, rd, er);
        chk("opt1", `BRC_OPT1_RST, rd);
        apb(1'b0, 12'h018, 32'h0000_0000, rd, er);
        chk("slverr", 32'h0000_0001, 32'(er));
        chk("init idle", 32'h0000_0001, 32'(init_n_out));
        apb(1'b1, `BRC_OFS_CTRL, 32'h0000_0001, rd, er);
        apb(1'b1, `BRC_OFS_CMD, 32'h0000_0001, rd, er);
        clk_sel_in.master_mode <= 1'b1;
        repeat (60) @(posedge pclk);
        chk("run no done", 32'h0000_0000, 32'(running));
        done_in <= 1'b1;
        clk_sel_in <= '0;
        repeat (60) @(posedge pclk);
        chk("run no clock", 32'h0000_0000, 32'(running));
        // Port clock outranks master clock, and here the port clock is dead
        clk_sel_in <= 4'b1010;
        tick_en <= 4'h7;
        repeat (60) @(posedge pclk);
        chk("port clock first", 32'h0000_0000, 32'(running));
        clk_sel_in <= 4'b0010;
        tick_en <= 4'hF;
        wait_stat(`BRC_STAT_GOLDEN_OK, 1'b1);
        repeat (250) @(posedge pclk);
        chk("clean", 32'h0000_0000, 32'(mismatch_flag));
        upset <= 1'b1;
        wait_stat(`BRC_STAT_MISMATCH, 1'b1);
        chk("init err", 32'h0000_0000, 32'(init_n_out));
        chk("init oe", 32'h0000_0001, 32'(init_n_oe));
        chk("done", 32'h0000_0001, 32'(done_out));
        repeat (250) @(posedge pclk);
        chk("held", 32'h0000_0001, 32'(mismatch_flag));
        access_in.port_active <= 1'b1;
        wait_stat(`BRC_STAT_MISMATCH, 1'b0);
        chk("stopped", 32'h0000_0000, 32'(running));
        access_in <= '0;
        upset <= 1'b0;
        // Access must have left the synchronisers, or it parks the interface again
        repeat (8) @(posedge pclk);
        apb(1'b1, `BRC_OFS_CMD, 32'h0000_0001, rd, er);
        wait_stat(`BRC_STAT_GOLDEN_OK, 1'b1);
        apb(1'b1, `BRC_OFS_OPT1, 32'h0000_0001, rd, er);
        upset <= 1'b1;
        wait_stat(`BRC_STAT_MISMATCH, 1'b1);
        chk("init excluded", 32'h0000_0000, 32'(init_n_oe));
        for (int i = 0; i < 3; i++) begin
            jtag_ir_cfg_in <= 3'h1 << i;
            repeat (20) @(posedge pclk);
            chk("ir block", 32'h0000_0000, 32'({running, mismatch_flag}));
            jtag_ir_cfg_in <= 3'h0;
            apb(1'b1, `BRC_OFS_CMD, 32'h0000_0001, rd, er);
        end
        wait_stat(`BRC_STAT_GOLDEN_OK, 1'b1);
        for (int i = 0; i < 2; i++) begin
            apb(1'b0, `BRC_OFS_GOLD, 32'h0000_0000, g0, er);
            upset <= ~upset;
            apb(1'b1, `BRC_OFS_CMD, i ? 32'h0000_0008 : 32'h0000_0002, rd, er);
            repeat (300) @(posedge pclk);
            apb(1'b0, `BRC_OFS_GOLD, 32'h0000_0000, rd, er);
            total_checks++;
            if (rd === g0) begin
                failures++;
                $display("[ERR] gold exp change got %h", rd);
            end
        end
        upset <= ~upset;
        wait_stat(`BRC_STAT_MISMATCH, 1'b1);
        apb(1'b1, `BRC_OFS_CMD, 32'h0000_0001, rd, er);
        wait_stat(`BRC_STAT_MISMATCH, 1'b0);
        summarize();
    end
endmodule : brc_checker_tb

bind brc_checker brc_checker_props #(.ADDR_W(ADDR_W), .FRAME_WORDS(FRAME_WORDS))
    i_brc_checker_props (.pclk, .presetn, .psel, .penable, .pwrite, .pready, .pslverr,
    .done_in, .access_in, .jtag_ir_cfg_in, .mem_addr, .mem_rd, .mismatch_flag,
    .init_n_out, .done_out, .running);
